// ===== rds_checker.sv
/* Port checker for rds_top, bound to every instance.
   Assumes writes land at the edge where waitrequest is sampled low. */
`timescale 1ns/1ns
module rds_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Bus
  input wire logic [rds_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [rds_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // Pins
  input wire logic line_sync_in,
  input wire logic pll_locked,
  input wire logic ref_out,
  input wire logic pd_ref_out,
  input wire logic lock_ref_out,
  input wire logic filter_internal_out
);
  logic [6:0] div_r;
  logic [1:0] pf_r;
  logic sel_r;
  logic flt_r;
  logic dirty_r;
  logic [7:0] low_r;
  logic [1:0] up_r;
  wire logic wr = avs_write && !avs_waitrequest && avs_byteenable[0];
  // Any divider write since the last REF high leaves the next low phase unjudged
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      div_r <= 7'h00;
      sel_r <= 1'b1;
      pf_r <= 2'h0;
      flt_r <= 1'b0;
      dirty_r <= 1'b1;
      low_r <= 8'h00;
      up_r <= 2'h0;
    end else begin
      if (wr && avs_address == 8'h1C) begin
        div_r <= avs_writedata[6:0];
        sel_r <= avs_writedata[7];
      end
      if (wr && avs_address == 8'h00) pf_r <= avs_writedata[7:6];
      if (wr && avs_address == 8'h10) flt_r <= avs_writedata[7];
      dirty_r <= (wr && avs_address == 8'h1C) || (dirty_r && !ref_out);
      low_r <= ref_out ? 8'h00 : low_r + 8'h01;
      up_r <= {up_r[0], 1'b1};
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_ref_high_one: assert property ($rose(ref_out) |=> !ref_out)
    else $error("ref high longer than one cycle");
  a_ref_low_len: assert property (
    $rose(ref_out) && !dirty_r |-> low_r == {1'b0, div_r} + 8'h01)
    else $error("ref low time wrong");
  a_pd_select: assert property (up_r[1] |->
    pd_ref_out == ($past(sel_r) ? $past(ref_out) : $past(line_sync_in)))
    else $error("phase detector source wrong");
  a_lock_ref_pin: assert property (
    up_r[1] && $past(pf_r) == 2'h3 |-> lock_ref_out == $past(ref_out))
    else $error("ref not on lock pin");
  a_lock_other: assert property (up_r[1] && $past(pf_r) != 2'h3 |->
    lock_ref_out == ($past(pf_r) == 2'h1 && $past(pll_locked)))
    else $error("lock pin value wrong");
  a_filter_sel: assert property (filter_internal_out == flt_r)
    else $error("filter select wrong");
  a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_wait_answer: assert property ($rose(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer in time");
endmodule // rds_checker

bind rds_top rds_checker u_chk (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
  .line_sync_in(line_sync_in), .pll_locked(pll_locked), .ref_out(ref_out),
  .pd_ref_out(pd_ref_out), .lock_ref_out(lock_ref_out),
  .filter_internal_out(filter_internal_out));

// ===== rds_pin_mux.sv
/*
  Output selection for the phase detector reference and the shared
  lock/reference pin, both registered.
  Assumes line sync and lock inputs are synchronous to sys_clk.
*/
`timescale 1ns/1ns
module rds_pin_mux (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Settings
  input wire logic [1:0] pin_func,
  input wire logic in_sel,
  // Sources
  input wire logic ref_in,
  input wire logic line_sync_in,
  input wire logic pll_locked,
  // Selected outputs
  output logic pd_ref_out,
  output logic lock_ref_out
);

  typedef struct packed {
    logic pd_ref;
    logic lock_ref;
  } rds_mux_state_t;

  rds_mux_state_t st_r;
  rds_mux_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.pd_ref = in_sel ? ref_in : line_sync_in;
    unique case (rds_pkg::rds_pin_func_t'(pin_func))
      rds_pkg::RDS_PF_ZERO: st_nxt.lock_ref = 1'b0;
      rds_pkg::RDS_PF_LOCK: st_nxt.lock_ref = pll_locked;
      // Reserved code: hold the pin low rather than leave it undefined
      rds_pkg::RDS_PF_RSVD: st_nxt.lock_ref = 1'b0;
      rds_pkg::RDS_PF_REF: st_nxt.lock_ref = ref_in;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pd_ref_out = st_r.pd_ref;
  assign lock_ref_out = st_r.lock_ref;

endmodule // rds_pin_mux

// ===== rds_pkg.sv
/*
  Shared constants and types for the reference divider and select block:
  register indices, field positions, reset values, pin function codes and
  bus handshake states.
  Assumes a single 50 MHz system clock that stands in for the oscillator input.
*/
package rds_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 5;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 6;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PIN_CTRL = 5'h00;
  localparam logic [IDX_W-1:0] IDX_FILTER = 5'h04;
  localparam logic [IDX_W-1:0] IDX_DIVIDER = 5'h07;
  localparam logic [IDX_W-1:0] IDX_STATUS = 5'h12;
  localparam logic [IDX_W-1:0] IDX_REF_COUNT = 5'h13;

  // Field positions
  localparam int PIN_FUNC_LSB = 6;
  localparam int PIN_FUNC_MSB = 7;
  localparam int FILTER_SEL_BIT = 7;
  localparam int DIV_W = 7;
  localparam int DIV_MSB = 6;
  localparam int IN_SEL_BIT = 7;
  localparam int STAT_LOCK_BIT = 1;
  localparam int CNT_W = 8;
  localparam int CNT_DIVZERO_BIT = 8;
  localparam int CNT_REF_BIT = 9;

  // Reset values
  localparam logic [1:0] PIN_FUNC_RST = 2'h0;
  localparam logic FILTER_SEL_RST = 1'b0;
  localparam logic [DIV_W-1:0] DIV_RST = 7'h00;
  localparam logic IN_SEL_RST = 1'b1;
  localparam logic [CNT_W-1:0] REF_COUNT_RST = 8'h00;

  // REF shape: high one input period, low for divider plus one periods
  localparam logic [DIV_W-1:0] DIV_ZERO = 7'h00;
  localparam logic [DIV_W-1:0] CNT_STEP = 7'h01;
  localparam logic [CNT_W-1:0] REF_COUNT_STEP = 8'h01;

  typedef enum logic [1:0] {
    RDS_PF_ZERO = 2'b00,
    RDS_PF_LOCK = 2'b01,
    RDS_PF_RSVD = 2'b10,
    RDS_PF_REF = 2'b11
  } rds_pin_func_t;

  typedef enum logic [0:0] {
    RDS_BUS_IDLE = 1'b0,
    RDS_BUS_ACK = 1'b1
  } rds_bus_state_t;

endpackage : rds_pkg

// ===== rds_ref_gen.sv
/*
  REF pulse generator: a down counter that reloads from the divider field
  at each falling REF edge.
  Assumes the divider value is stable or changes only between cycles of REF.
*/
`timescale 1ns/1ns
module rds_ref_gen (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Divider setting
  input wire logic [rds_pkg::DIV_W-1:0] divider,
  // REF and its start pulse
  output logic ref_out,
  output logic ref_start
);

  typedef struct packed {
    logic ref_lvl;
    logic start;
    logic [rds_pkg::DIV_W-1:0] cnt;
  } rds_ref_state_t;

  rds_ref_state_t st_r;
  rds_ref_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.start = 1'b0;
    if (st_r.ref_lvl) begin
      // High lasts exactly one period, then reload the low count
      st_nxt.ref_lvl = 1'b0;
      st_nxt.cnt = divider;
    end else if (st_r.cnt == rds_pkg::DIV_ZERO) begin
      // Low ran divider plus one periods; full cycle is divider plus two
      st_nxt.ref_lvl = 1'b1;
      st_nxt.start = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt - rds_pkg::CNT_STEP;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ref_out = st_r.ref_lvl;
  assign ref_start = st_r.start;

endmodule // rds_ref_gen

// ===== rds_sync_model.sv
/* Far side model: line sync source and PLL lock flag.
   Assumes the same clock as the block; lock follows a bench request. */
`timescale 1ns/1ns
module rds_sync_model (
  // Clock
  input wire logic sys_clk,
  // Control
  input wire logic lock_req,
  // Sources
  output logic line_sync_in,
  output logic pll_locked
);
  logic [2:0] ph_r = 3'h0;
  logic lk_r = 1'b0;
  // Sync toggles every four cycles so a stuck mux shows quickly
  always @(posedge sys_clk) begin
    ph_r <= ph_r + 3'h1;
    lk_r <= lock_req;
  end
  assign line_sync_in = ph_r[2];
  assign pll_locked = lk_r;
endmodule // rds_sync_model

// ===== rds_top.sv
/*
  Reference divider and select block with its Avalon-MM register slave.
  Assumes sys_clk is the oscillator input and all inputs are synchronous.
*/
// Local design decisions: the Avalon-MM register port and the register addresses.
// Behaviour
// - REF stays high for exactly one oscillator period per cycle.
// - REF stays low for divider field plus one oscillator periods.
// - One REF cycle spans divider plus two periods.
// - Divider one gives the smallest division, three; the code stores divider zero as written and it gives two.
// - Divider all ones gives the largest division, one hundred twenty nine.
// - Input select one feeds REF to the phase detector.
// - Pin function eleven drives REF onto the lock/reference pin.
// - Filter select zero picks external filter, one picks internal.
// - Input select zero feeds line sync to the phase detector.
// - Pin function 00 drives zero, 01 shows lock, 10 reserved.
`timescale 1ns/1ns
module rds_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [rds_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [rds_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [rds_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Timing inputs
  input wire logic line_sync_in,
  input wire logic pll_locked,
  // Outputs
  output logic ref_out,
  output logic pd_ref_out,
  output logic lock_ref_out,
  output logic filter_internal_out
);

  typedef struct packed {
    rds_pkg::rds_bus_state_t bus_state;
    logic waitrequest;
    logic [rds_pkg::DATA_W-1:0] readdata;
    logic [1:0] pin_func;
    logic filter_sel;
    logic [rds_pkg::DIV_W-1:0] divider;
    logic in_sel;
    logic [rds_pkg::CNT_W-1:0] ref_count;
  } rds_top_state_t;

  rds_top_state_t st_r;
  rds_top_state_t st_nxt;
  logic ref_lvl;
  logic ref_start;
  logic [rds_pkg::IDX_W-1:0] idx;
  logic hit;
  logic wr_low;
  logic cnt_clr;
  logic [rds_pkg::DATA_W-1:0] rd_word;

  function automatic logic [rds_pkg::IDX_W-1:0] reg_index(
    input logic [rds_pkg::ADDR_W-1:0] addr
  );
    return addr[rds_pkg::IDX_MSB:rds_pkg::IDX_LSB];
  endfunction

  // Word aligned, below 0x80 and one of the five implemented indices
  function automatic logic reg_mapped(input logic [rds_pkg::ADDR_W-1:0] addr);
    logic [rds_pkg::IDX_W-1:0] i;
    i = addr[rds_pkg::IDX_MSB:rds_pkg::IDX_LSB];
    return (addr[1:0] == 2'h0) && !addr[rds_pkg::ADDR_W-1] &&
      ((i == rds_pkg::IDX_PIN_CTRL) || (i == rds_pkg::IDX_FILTER) ||
       (i == rds_pkg::IDX_DIVIDER) || (i == rds_pkg::IDX_STATUS) ||
       (i == rds_pkg::IDX_REF_COUNT));
  endfunction

  rds_ref_gen u_ref_gen (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .divider(st_r.divider),
    .ref_out(ref_lvl),
    .ref_start(ref_start)
  );

  rds_pin_mux u_pin_mux (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pin_func(st_r.pin_func),
    .in_sel(st_r.in_sel),
    .ref_in(ref_lvl),
    .line_sync_in(line_sync_in),
    .pll_locked(pll_locked),
    .pd_ref_out(pd_ref_out),
    .lock_ref_out(lock_ref_out)
  );

  always_comb begin
    st_nxt = st_r;
    idx = reg_index(avs_address);
    hit = reg_mapped(avs_address);
    wr_low = 1'b0;
    cnt_clr = 1'b0;
    rd_word = '0;
    unique case (idx)
      rds_pkg::IDX_PIN_CTRL: rd_word[rds_pkg::PIN_FUNC_MSB:rds_pkg::PIN_FUNC_LSB] = st_r.pin_func;
      rds_pkg::IDX_FILTER: rd_word[rds_pkg::FILTER_SEL_BIT] = st_r.filter_sel;
      rds_pkg::IDX_DIVIDER: begin
        rd_word[rds_pkg::DIV_MSB:0] = st_r.divider;
        rd_word[rds_pkg::IN_SEL_BIT] = st_r.in_sel;
      end
      rds_pkg::IDX_STATUS: rd_word[rds_pkg::STAT_LOCK_BIT] = pll_locked;
      rds_pkg::IDX_REF_COUNT: begin
        rd_word[rds_pkg::CNT_W-1:0] = st_r.ref_count;
        rd_word[rds_pkg::CNT_DIVZERO_BIT] = (st_r.divider == rds_pkg::DIV_ZERO);
        rd_word[rds_pkg::CNT_REF_BIT] = ref_lvl;
      end
      default: rd_word = '0;
    endcase
    unique case (st_r.bus_state)
      rds_pkg::RDS_BUS_IDLE: begin
        // One wait cycle gives a registered read and a clean write edge
        if (avs_read || avs_write) begin
          st_nxt.bus_state = rds_pkg::RDS_BUS_ACK;
          st_nxt.waitrequest = 1'b0;
          st_nxt.readdata = (avs_read && hit) ? rd_word : '0;
        end
      end
      rds_pkg::RDS_BUS_ACK: begin
        st_nxt.bus_state = rds_pkg::RDS_BUS_IDLE;
        st_nxt.waitrequest = 1'b1;
        wr_low = avs_write && hit && avs_byteenable[0];
      end
    endcase
    if (wr_low) begin
      unique case (idx)
        rds_pkg::IDX_PIN_CTRL:
          st_nxt.pin_func = avs_writedata[rds_pkg::PIN_FUNC_MSB:rds_pkg::PIN_FUNC_LSB];
        rds_pkg::IDX_FILTER: st_nxt.filter_sel = avs_writedata[rds_pkg::FILTER_SEL_BIT];
        rds_pkg::IDX_DIVIDER: begin
          // Zero is reserved; stored as written, reported in the count register
          st_nxt.divider = avs_writedata[rds_pkg::DIV_MSB:0];
          st_nxt.in_sel = avs_writedata[rds_pkg::IN_SEL_BIT];
        end
        rds_pkg::IDX_REF_COUNT: cnt_clr = 1'b1;
        default: st_nxt.ref_count = st_r.ref_count;
      endcase
    end
    // A REF start in the clearing cycle is still counted
    if (cnt_clr) begin
      st_nxt.ref_count = ref_start ? rds_pkg::REF_COUNT_STEP : rds_pkg::REF_COUNT_RST;
    end else if (ref_start) begin
      st_nxt.ref_count = st_r.ref_count + rds_pkg::REF_COUNT_STEP;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_r.bus_state <= rds_pkg::RDS_BUS_IDLE;
      st_r.waitrequest <= 1'b1;
      st_r.readdata <= '0;
      st_r.pin_func <= rds_pkg::PIN_FUNC_RST;
      st_r.filter_sel <= rds_pkg::FILTER_SEL_RST;
      st_r.divider <= rds_pkg::DIV_RST;
      st_r.in_sel <= rds_pkg::IN_SEL_RST;
      st_r.ref_count <= rds_pkg::REF_COUNT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata = st_r.readdata;
  assign avs_waitrequest = st_r.waitrequest;
  assign ref_out = ref_lvl;
  assign filter_internal_out = st_r.filter_sel;

endmodule // rds_top

// ===== tb.sv
/* Self-checking bench for rds_top over Avalon-MM.
   Assumes the far side model supplies line sync and lock. */
`timescale 1ns/1ns
module tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic line_sync_in, pll_locked, ref_out, pd_ref_out, lock_ref_out, filter_internal_out;
  logic lock_req = 1'b0;
  logic [31:0] q;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #10 sys_clk = ~sys_clk;
  rds_top uut (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .line_sync_in(line_sync_in), .pll_locked(pll_locked),
    .ref_out(ref_out), .pd_ref_out(pd_ref_out), .lock_ref_out(lock_ref_out),
    .filter_internal_out(filter_internal_out));
  rds_sync_model u_far (.sys_clk(sys_clk), .lock_req(lock_req), .line_sync_in(line_sync_in),
    .pll_locked(pll_locked));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_write <= w;
    avs_read <= ~w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task rise;
    do @(posedge sys_clk); while (ref_out !== 1'b0);
    do @(posedge sys_clk); while (ref_out !== 1'b1);
  endtask
  task period(input logic [6:0] d);
    int hi, lo;
    bus(1'b1, 8'h1C, {24'h0, 1'b1, d});
    // The cycle after a write may still use the old value
    rise();
    rise();
    hi = 0;
    lo = 0;
    while (ref_out === 1'b1) begin
      hi++;
      @(posedge sys_clk);
    end
    while (ref_out === 1'b0) begin
      lo++;
      @(posedge sys_clk);
    end
    check(32'(hi), 32'h1);
    check(32'(lo), 32'(d) + 32'h1);
    check(32'(hi + lo), 32'(d) + 32'h2);
  endtask
  task follow(input logic pin, input logic [1:0] src);
    logic p_ref, p_ls, p_lk, exp;
    @(posedge sys_clk);
    repeat (20) begin
      p_ref = ref_out;
      p_ls = line_sync_in;
      p_lk = pll_locked;
      @(posedge sys_clk);
      exp = src == 2'h0 ? p_ls : src == 2'h1 ? p_ref : src == 2'h2 ? p_lk : 1'b0;
      check({31'h0, pin ? lock_ref_out : pd_ref_out}, {31'h0, exp});
    end
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    logic [6:0] dv [3];
    logic [1:0] sm [4];
    dv = '{7'h01, 7'h7F, 7'h05}; // Zero is never programmed
    sm = '{2'h3, 2'h2, 2'h3, 2'h1};
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    bus(1'b0, 8'h1C, 32'h0);
    check(q, 32'h80);
    for (int i = 0; i < 3; i++) period(dv[i]);
    $display("test divider done");
    bus(1'b1, 8'h1C, 32'h01);
    follow(1'b0, 2'h0);
    bus(1'b1, 8'h1C, 32'h81);
    follow(1'b0, 2'h1);
    $display("test input select done");
    for (int k = 0; k < 8; k++) begin
      lock_req <= k[2];
      bus(1'b1, 8'h00, {24'h0, 2'(k), 6'h00});
      follow(1'b1, sm[k % 4]);
    end
    bus(1'b0, 8'h48, 32'h0);
    check(q, 32'h2);
    bus(1'b0, 8'h4C, 32'h0);
    check(q & 32'h100, 32'h0);
    $display("test pin function done");
    bus(1'b1, 8'h10, 32'h80);
    @(posedge sys_clk);
    check({31'h0, filter_internal_out}, 32'h1);
    avs_byteenable <= 4'h0;
    bus(1'b1, 8'h10, 32'h0);
    avs_byteenable <= 4'hF;
    bus(1'b0, 8'h10, 32'h0);
    check(q, 32'h80);
    bus(1'b1, 8'h10, 32'h0);
    @(posedge sys_clk);
    check({31'h0, filter_internal_out}, 32'h0);
    bus(1'b0, 8'h44, 32'h0);
    check(q, 32'h0);
    $display("test filter and bus done");
    give_verdict();
  end
endmodule // tb
